// file: logic/sdfp_top.sv
// Fault protection and alarm lamp logic of a two-phase stepper driver.
// Assumes detector and all-windings-off inputs are asynchronous pins,
// and that rst is the power-on reset of the driver.
`timescale 1ns/1ps

// How it works
// - Any detector trip drives fault alarm output to OFF.
// - Motor current is cut in the same cycle the alarm goes OFF.
// - While latched, lamp blinks a cause-dependent count, repeated.
// - Overheat trips and gives two blinks per group.
// - Overvoltage trips and gives three blinks per group.
// - Overcurrent trips and gives five blinks per group.
// - Fault stays latched until power-on reset only.
// - All-windings-off ON removes excitation; OFF restores it unless a fault is latched.
module sdfp_top (
    input wire logic clk,
    input wire logic rst,
    input wire sdfp_pkg::sdfp_det_t det_in,
    input wire logic all_windings_off_input,
    output logic fault_alarm_output,
    output logic motor_current_enable,
    output logic fault_indicator_lamp
);

    sdfp_pkg::sdfp_state_t st;
    sdfp_pkg::sdfp_state_t next_st;

    localparam int TMR_W = sdfp_pkg::TMR_W;

    function automatic logic [3:0] blinks_of(input sdfp_pkg::sdfp_cause_t c);
        case (c)
            sdfp_pkg::SDFP_C_HEAT: blinks_of = sdfp_pkg::BLINKS_OVERHEAT;
            sdfp_pkg::SDFP_C_VOLT: blinks_of = sdfp_pkg::BLINKS_OVERVOLT;
            sdfp_pkg::SDFP_C_CURR: blinks_of = sdfp_pkg::BLINKS_OVERCURR;
            default: blinks_of = sdfp_pkg::BLINKS_NONE;
        endcase
    endfunction : blinks_of

    // ******************************
    // Next state
    // ******************************
    always_comb begin
        next_st = st;
        next_st.det_s1 = det_in;
        next_st.det_s2 = st.det_s1;
        next_st.wnd_off_s1 = all_windings_off_input;
        next_st.wnd_off_s2 = st.wnd_off_s1;
        if (st.cause == sdfp_pkg::SDFP_C_NONE) begin
            if (st.det_s2.overcurr) begin
                next_st.cause = sdfp_pkg::SDFP_C_CURR;
            end else if (st.det_s2.overvolt) begin
                next_st.cause = sdfp_pkg::SDFP_C_VOLT;
            end else if (st.det_s2.overheat) begin
                next_st.cause = sdfp_pkg::SDFP_C_HEAT;
            end
        end
        // Alarm OFF on any latched fault
        next_st.fault_alarm_output = (next_st.cause == sdfp_pkg::SDFP_C_NONE);
        // Current cut with alarm or windings off
        next_st.motor_current_enable = (next_st.cause == sdfp_pkg::SDFP_C_NONE)
            && !st.wnd_off_s2;
        if (st.tmr != '0) begin
            next_st.tmr = st.tmr - 1'b1;
        end
        case (st.lamp_st)
            sdfp_pkg::SDFP_L_IDLE: begin
                if (st.cause != sdfp_pkg::SDFP_C_NONE) begin
                    next_st.lamp_st = sdfp_pkg::SDFP_L_ON;
                    next_st.blink_cnt = blinks_of(st.cause);
                    next_st.tmr = TMR_W'(sdfp_pkg::BLINK_ON_CYC - 1);
                end
            end
            sdfp_pkg::SDFP_L_ON: begin
                if (st.tmr == '0) begin
                    next_st.blink_cnt = st.blink_cnt - 1'b1;
                    if (st.blink_cnt == 4'h1) begin
                        next_st.lamp_st = sdfp_pkg::SDFP_L_GAP;
                        next_st.tmr = TMR_W'(sdfp_pkg::GROUP_GAP_CYC - 1);
                    end else begin
                        next_st.lamp_st = sdfp_pkg::SDFP_L_OFF;
                        next_st.tmr = TMR_W'(sdfp_pkg::BLINK_OFF_CYC - 1);
                    end
                end
            end
            sdfp_pkg::SDFP_L_OFF: begin
                if (st.tmr == '0) begin
                    next_st.lamp_st = sdfp_pkg::SDFP_L_ON;
                    next_st.tmr = TMR_W'(sdfp_pkg::BLINK_ON_CYC - 1);
                end
            end
            sdfp_pkg::SDFP_L_GAP: begin
                if (st.tmr == '0) begin
                    next_st.lamp_st = sdfp_pkg::SDFP_L_ON;
                    next_st.blink_cnt = blinks_of(st.cause);
                    next_st.tmr = TMR_W'(sdfp_pkg::BLINK_ON_CYC - 1);
                end
            end
            default: next_st.lamp_st = sdfp_pkg::SDFP_L_IDLE;
        endcase
        next_st.fault_indicator_lamp = (next_st.lamp_st == sdfp_pkg::SDFP_L_ON);
    end

    // ******************************
    // Registers
    // ******************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '{default: '0, fault_alarm_output: 1'b1,
                cause: sdfp_pkg::SDFP_C_NONE, lamp_st: sdfp_pkg::SDFP_L_IDLE};
        end else begin
            st <= next_st;
        end
    end

    assign fault_alarm_output = st.fault_alarm_output;
    assign motor_current_enable = st.motor_current_enable;
    assign fault_indicator_lamp = st.fault_indicator_lamp;

    // ******************************
    // Checks
    // ******************************
    // Alarm and current drop together
    alarm_cuts_a: assert property (@(posedge clk) disable iff (rst)
        $fell(fault_alarm_output) |-> !motor_current_enable)
        else $error("current not cut with alarm");
    // Trip reaches alarm in three cycles
    trip_alarm_a: assert property (@(posedge clk) disable iff (rst)
        (det_in != '0) |-> ##[1:4] !fault_alarm_output)
        else $error("alarm not off after trip");
    // Alarm never returns without reset
    alarm_latch_a: assert property (@(posedge clk) disable iff (rst)
        !fault_alarm_output |=> !fault_alarm_output)
        else $error("alarm returned on");
    // Windings off removes excitation; two sync stages plus output flop
    wind_cut_a: assert property (@(posedge clk) disable iff (rst)
        all_windings_off_input [*4] |-> !motor_current_enable)
        else $error("excitation not removed");
    // Windings restored when released and healthy
    wind_back_a: assert property (@(posedge clk) disable iff (rst)
        (!all_windings_off_input && fault_alarm_output) [*4] |-> motor_current_enable)
        else $error("excitation not restored");
    // Lamp dark while healthy
    lamp_dark_a: assert property (@(posedge clk) disable iff (rst)
        fault_alarm_output |-> !fault_indicator_lamp)
        else $error("lamp lit without fault");
    // Overheat blink count loaded
    heat_cnt_a: assert property (@(posedge clk) disable iff (rst)
        (st.lamp_st == sdfp_pkg::SDFP_L_IDLE && st.cause == sdfp_pkg::SDFP_C_HEAT)
        |=> st.blink_cnt == sdfp_pkg::BLINKS_OVERHEAT)
        else $error("overheat count wrong");
    // Overvoltage blink count loaded
    volt_cnt_a: assert property (@(posedge clk) disable iff (rst)
        (st.lamp_st == sdfp_pkg::SDFP_L_IDLE && st.cause == sdfp_pkg::SDFP_C_VOLT)
        |=> st.blink_cnt == sdfp_pkg::BLINKS_OVERVOLT)
        else $error("overvoltage count wrong");
    // Overcurrent blink count loaded
    curr_cnt_a: assert property (@(posedge clk) disable iff (rst)
        (st.lamp_st == sdfp_pkg::SDFP_L_IDLE && st.cause == sdfp_pkg::SDFP_C_CURR)
        |=> st.blink_cnt == sdfp_pkg::BLINKS_OVERCURR)
        else $error("overcurrent count wrong");
    // Last blink leads to the long gap
    group_gap_a: assert property (@(posedge clk) disable iff (rst)
        (st.lamp_st == sdfp_pkg::SDFP_L_ON && st.tmr == '0 && st.blink_cnt == 4'h1)
        |=> st.lamp_st == sdfp_pkg::SDFP_L_GAP
            && st.tmr == TMR_W'(sdfp_pkg::GROUP_GAP_CYC - 1))
        else $error("no group gap");

    // ******************************
    // Cause, current and lamp checks
    // ******************************
    // Cause frozen once latched
    cause_hold_a: assert property (@(posedge clk) disable iff (rst)
        st.cause != sdfp_pkg::SDFP_C_NONE |=> $stable(st.cause))
        else $error("cause changed after latch");
    // Overcurrent wins any tie
    curr_pick_a: assert property (@(posedge clk) disable iff (rst)
        (st.cause == sdfp_pkg::SDFP_C_NONE && st.det_s2.overcurr)
        |=> st.cause == sdfp_pkg::SDFP_C_CURR)
        else $error("overcurrent not latched");
    // Overvoltage latched when no overcurrent
    volt_pick_a: assert property (@(posedge clk) disable iff (rst)
        (st.cause == sdfp_pkg::SDFP_C_NONE && st.det_s2.overvolt && !st.det_s2.overcurr)
        |=> st.cause == sdfp_pkg::SDFP_C_VOLT)
        else $error("overvoltage not latched");
    // Overheat latched when alone
    heat_pick_a: assert property (@(posedge clk) disable iff (rst)
        (st.cause == sdfp_pkg::SDFP_C_NONE && st.det_s2.overheat
            && !st.det_s2.overvolt && !st.det_s2.overcurr)
        |=> st.cause == sdfp_pkg::SDFP_C_HEAT)
        else $error("overheat not latched");
    // No current while alarm is OFF
    fault_cut_a: assert property (@(posedge clk) disable iff (rst)
        !fault_alarm_output |-> !motor_current_enable)
        else $error("current on during fault");
    // Synced windings-off drops current next edge
    wind_sync_cut_a: assert property (@(posedge clk) disable iff (rst)
        st.wnd_off_s2 |=> !motor_current_enable)
        else $error("windings still excited");
    // Lamp lights one cycle after the alarm goes OFF
    lamp_start_a: assert property (@(posedge clk) disable iff (rst)
        $fell(fault_alarm_output) |=> fault_indicator_lamp)
        else $error("lamp not lit after trip");
    // Every lit phase starts with a full timer
    lamp_on_time_a: assert property (@(posedge clk) disable iff (rst)
        $rose(fault_indicator_lamp) |-> st.tmr == TMR_W'(sdfp_pkg::BLINK_ON_CYC - 1))
        else $error("lit phase timer wrong");
    // Lamp stays lit until its timer runs out
    lamp_hold_a: assert property (@(posedge clk) disable iff (rst)
        (fault_indicator_lamp && st.tmr != '0) |=> fault_indicator_lamp)
        else $error("lit phase cut short");
    // Sequencer idle while healthy
    lamp_idle_a: assert property (@(posedge clk) disable iff (rst)
        st.cause == sdfp_pkg::SDFP_C_NONE |-> st.lamp_st == sdfp_pkg::SDFP_L_IDLE)
        else $error("sequencer busy without fault");
    // Lit phase always has blinks left
    cnt_live_a: assert property (@(posedge clk) disable iff (rst)
        st.lamp_st == sdfp_pkg::SDFP_L_ON |-> st.blink_cnt != '0)
        else $error("blink count empty while lit");

endmodule : sdfp_top

// file: logic/sdfp_pkg.sv
// Package for the stepper driver fault protection block.
// Assumes a single 10 MHz clock; all timing derived from that rate.
package sdfp_pkg;

    // ******************************
    // Timing
    // ******************************
    localparam int CLK_HZ = 10_000_000;
    localparam int BLINK_ON_MS = 200;
    localparam int BLINK_OFF_MS = 200;
    localparam int GROUP_GAP_MS = 1200;
    localparam int BLINK_ON_CYC = CLK_HZ / 1000 * BLINK_ON_MS;
    localparam int BLINK_OFF_CYC = CLK_HZ / 1000 * BLINK_OFF_MS;
    localparam int GROUP_GAP_CYC = CLK_HZ / 1000 * GROUP_GAP_MS;
    localparam int TMR_W = 24;

    // ******************************
    // Fault causes and blink counts
    // ******************************
    localparam logic [3:0] BLINKS_OVERHEAT = 4'h2;
    localparam logic [3:0] BLINKS_OVERVOLT = 4'h3;
    localparam logic [3:0] BLINKS_OVERCURR = 4'h5;
    localparam logic [3:0] BLINKS_NONE = 4'h0;

    typedef enum logic [1:0] {
        SDFP_C_NONE,
        SDFP_C_HEAT,
        SDFP_C_VOLT,
        SDFP_C_CURR
    } sdfp_cause_t;

    typedef enum logic [1:0] {
        SDFP_L_IDLE,
        SDFP_L_ON,
        SDFP_L_OFF,
        SDFP_L_GAP
    } sdfp_lamp_t;

    typedef struct packed {
        logic overheat;
        logic overvolt;
        logic overcurr;
    } sdfp_det_t;

    typedef struct packed {
        sdfp_det_t det_s1;
        sdfp_det_t det_s2;
        logic wnd_off_s1;
        logic wnd_off_s2;
        sdfp_cause_t cause;
        sdfp_lamp_t lamp_st;
        logic [TMR_W-1:0] tmr;
        logic [3:0] blink_cnt;
        logic fault_alarm_output;
        logic motor_current_enable;
        logic fault_indicator_lamp;
    } sdfp_state_t;

endpackage : sdfp_pkg

// file: test/sdfp_ctrl_model.sv
// Motion controller model on the far side of the fault protection block.
// Assumes the bench tells it when to hold the windings-off input ON.
`timescale 1ns/1ps
module sdfp_ctrl_model (
    input wire logic off_req,
    input wire logic fault_alarm_output,
    output logic all_windings_off_input,
    output logic fault_seen
);
    // Never steps right after release; no pulses modelled
    assign all_windings_off_input = off_req;
    // Power-off hold shortened to the bench reset span
    assign fault_seen = !fault_alarm_output;
endmodule : sdfp_ctrl_model

// file: test/sdfp_top_tb_top.sv
// Self-checking bench for the fault protection block.
// Assumes 10 MHz clk; blink phases are far longer than the run, so only
// the first lit phase of the lamp is seen.
`timescale 1ns/1ps
module sdfp_top_tb_top;
    logic clk, rst, off_req, off_in, alarm, en, lamp, seen;
    sdfp_pkg::sdfp_det_t det;
    int n_fail, samples_checked, faulted, off_m;
    // Blink counts per scenario: heat, volt, curr, all three at once
    int want_b[4] = '{2, 3, 5, 5};
    sdfp_top dut_u (.clk(clk), .rst(rst), .det_in(det), .all_windings_off_input(off_in),
        .fault_alarm_output(alarm), .motor_current_enable(en), .fault_indicator_lamp(lamp));
    sdfp_ctrl_model ctrl_u (.off_req(off_req), .fault_alarm_output(alarm),
        .all_windings_off_input(off_in), .fault_seen(seen));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic end_sim();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    // ****************************************
    // Compare outputs with the integer model
    // ****************************************
    task automatic chk(int lp);
        samples_checked++;
        if (alarm !== 1'(faulted == 0) || en !== 1'(faulted == 0 && off_m == 0)
            || lamp !== 1'(lp) || seen !== 1'(faulted != 0)) begin
            n_fail++;
            $display("BAD %0t alarm %b enable %b lamp %b", $time, alarm, en, lamp);
        end
    endtask : chk
    // Blink count is far too slow to watch at the pin within the run
    task automatic chk_blinks(int want);
        samples_checked++;
        if (dut_u.st.blink_cnt !== 4'(want)) begin
            n_fail++;
            $display("BAD %0t blinks %0d want %0d", $time, dut_u.st.blink_cnt, want);
        end
    endtask : chk_blinks
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : cyc
    initial begin
        #(100 * 20000);
        n_fail++;
        end_sim();
    end
    initial begin
        void'($urandom(6442));
        det = '0;
        off_req = 1'b0;
        rst = 1'b1;
        n_fail = 0;
        samples_checked = 0;
        faulted = 0;
        off_m = 1;
        cyc(5);
        chk(0);
        rst = 1'b0;
        // Synchronisers clear low, so excitation returns at the first edge
        off_m = 0;
        cyc(2);
        chk(0);
        cyc(1);
        chk(0);
        off_req = 1'b1;
        cyc(3);
        off_m = 1;
        chk(0);
        off_req = 1'b0;
        cyc(3);
        off_m = 0;
        chk(0);
        for (int k = 0; k < 4; k++) begin
            // Cause by index; index 3 trips all three at once
            det = (k == 3) ? 3'h7 : 3'(4 >> k);
            cyc(2);
            chk(0);
            cyc(1);
            faulted = 1;
            chk(0);
            cyc(1);
            chk(1);
            chk_blinks(want_b[k]);
            det = 3'($urandom % 8);
            off_req = 1'($urandom % 2);
            cyc(10 + $urandom % 200);
            off_m = off_req;
            chk(1);
            chk_blinks(want_b[k]);
            off_req = 1'b0;
            det = '0;
            rst = 1'b1;
            cyc(5);
            faulted = 0;
            off_m = 1;
            chk(0);
            rst = 1'b0;
            cyc(3);
            off_m = 0;
            chk(0);
        end
        end_sim();
    end
endmodule : sdfp_top_tb_top
